// File: src/cstwf_pkg.sv
// constants for the cyclic sense timers and wake filter block
// assumes a 200 MHz system clock and byte addressing on the register bus
package cstwf_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_WAKE_FILTER  = 8'h09;
  localparam logic [7:0] IDX_TIMER_ONE    = 8'h0c;
  localparam logic [7:0] IDX_TIMER_TWO    = 8'h0d;
  localparam logic [7:0] IDX_SWITCH_ROUTE = 8'h14;
  localparam logic [7:0] IDX_STATUS       = 8'h18;
  // field positions and widths
  localparam int ON_LSB     = 4;
  localparam int PER_LSB    = 0;
  localparam int WKEN_LSB   = 6;
  localparam int FILT_WIDTH = 2;
  localparam int HS_WIDTH   = 3;
  // reset values
  localparam logic [7:0]  RST_WAKE_FILTER  = 8'h00;
  localparam logic [7:0]  RST_TIMER        = 8'h00;
  localparam logic [13:0] RST_SWITCH_ROUTE = 14'h0000;
  // on-time codes and the reserved period code
  localparam logic [2:0] ON_HOLD_LOW  = 3'h0;
  localparam logic [2:0] ON_HOLD_HIGH = 3'h6;
  localparam logic [2:0] ON_RESERVED  = 3'h7;
  localparam logic [2:0] PER_RESERVED = 3'h7;
  // filter selections
  localparam logic [1:0] FILT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FILT_STATIC_LONG  = 2'h1;
  localparam logic [1:0] FILT_CYCLIC_ONE   = 2'h2;
  localparam logic [1:0] FILT_CYCLIC_TWO   = 2'h3;
  // switch configuration codes
  localparam logic [2:0] HS_OFF       = 3'h0;
  localparam logic [2:0] HS_ON        = 3'h1;
  localparam logic [2:0] HS_TIMER_ONE = 3'h2;
  localparam logic [2:0] HS_TIMER_TWO = 3'h3;
  // timing
  localparam int CLK_MHZ          = 200;
  localparam int TICK_TIME_NS     = 100000;
  localparam int FILT_SHORT_NS    = 16000;
  localparam int FILT_LONG_NS     = 64000;
  localparam int TICK_CYCLES      = TICK_TIME_NS * CLK_MHZ / 1000;
  localparam int FILT_SHORT_CYC   = FILT_SHORT_NS * CLK_MHZ / 1000;
  localparam int FILT_LONG_CYC    = FILT_LONG_NS * CLK_MHZ / 1000;
  // on-times and periods in 0.1 ms ticks, and the timer counter width
  localparam int ON_T1 = 1;
  localparam int ON_T2 = 3;
  localparam int ON_T3 = 10;
  localparam int ON_T4 = 100;
  localparam int ON_T5 = 200;
  localparam int PER_T0 = 100;
  localparam int PER_T1 = 200;
  localparam int PER_T2 = 500;
  localparam int PER_T3 = 1000;
  localparam int PER_T4 = 2000;
  localparam int PER_T5 = 10000;
  localparam int PER_T6 = 20000;
  localparam int TCNT_W = 15;
endpackage : cstwf_pkg

// File: src/cstwf_top.sv
// cyclic sense timers, switch routing and wake input filter setup
// assumes synchronous inputs and an Avalon-MM master on the register port
//
// Overview of operation
// RL1 - reserved bits of filter and timer registers always read zero
// RL2 - filter register holds two-bit selections: input three 5:4, two 3:2, one 1:0
// RL3 - selection 00 is static 16us filter, 01 is static 64us filter
// RL4 - selection 10 samples at timer one on-time end, 11 at timer two
// RL5 - software routes a timer to a switch when choosing cyclic filtering
// RL6 - on-time codes 001 to 101 give 0.1, 0.3, 1, 10, 20 ms
// RL7 - on-time code 000 stops timer with output low
// RL8 - on-time code 110 stops timer with output high; 111 reserved
// RL9 - period codes 000 to 110 give 10 ms up to 2 s; 111 reserved
// RL10 - writing a running on-time code starts the timer at once
// RL11 - restart clearing switches also clears timer period and on-time
// RL12 - cyclic wake and cyclic sensing run together from one timer
// RL13 - timer two has its own register with identical encodings
// RL14 - reset clears all; restart clears timers and switch route bits 13:2 only
// RL15 - per-timer wake enable makes the timer a cyclic wake source
// RL16 - switch code 010 follows timer one, 011 follows timer two
// RL17 - running timer goes high each period start, low after on-time
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/100ps
module cstwf_top
  import cstwf_pkg::*;
#(
  parameter int TICK_CYC  = TICK_CYCLES,
  parameter int FSHORT_CYC = FILT_SHORT_CYC,
  parameter int FLONG_CYC  = FILT_LONG_CYC
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // device mode events
  input  wire logic        soft_reset,
  input  wire logic        restart_req,
  // wake pins
  input  wire logic [2:0]  wake_input,
  // outputs
  output logic [3:0]       high_side_switch_output,
  output logic [2:0]       wake_level,
  output logic [1:0]       cyclic_wake_pulse
);

  logic        waitrequest_ff;
  logic [31:0] readdata_ff;
  logic [5:0]  wake_filter_select_ff;
  logic [2:0]  on_ff [2];
  logic [2:0]  per_ff [2];
  logic [1:0]  wake_en_ff;
  logic [11:0] hs_cfg_ff;
  logic [3:0]  hs_out_ff;
  logic [1:0]  timer_out_ff;
  logic [1:0]  timer_end_ff;
  logic [1:0]  cyc_wake_ff;
  logic [1:0]  start;
  logic [2:0]  wake_level_ff;
  logic [15:0] tick_cnt_ff;
  logic        tick;
  logic        wr_ok;
  logic [7:0]  widx;
  logic [7:0]  rd_mux;

  assign wr_ok = write & ~waitrequest_ff & byteenable[0] & (address[1:0] == 2'h0);
  assign widx  = {2'h0, address[7:2]};
  assign tick  = (tick_cnt_ff == 16'(TICK_CYC - 1));

  function automatic logic [TCNT_W-1:0] on_ticks(input logic [2:0] c);
    unique case (c)
      3'h1:    on_ticks = TCNT_W'(ON_T1);
      3'h2:    on_ticks = TCNT_W'(ON_T2);
      3'h3:    on_ticks = TCNT_W'(ON_T3);
      3'h4:    on_ticks = TCNT_W'(ON_T4);
      3'h5:    on_ticks = TCNT_W'(ON_T5);
      default: on_ticks = '0;
    endcase
  endfunction : on_ticks

  function automatic logic [TCNT_W-1:0] per_ticks(input logic [2:0] c);
    unique case (c)
      3'h0:    per_ticks = TCNT_W'(PER_T0);
      3'h1:    per_ticks = TCNT_W'(PER_T1);
      3'h2:    per_ticks = TCNT_W'(PER_T2);
      3'h3:    per_ticks = TCNT_W'(PER_T3);
      3'h4:    per_ticks = TCNT_W'(PER_T4);
      3'h5:    per_ticks = TCNT_W'(PER_T5);
      3'h6:    per_ticks = TCNT_W'(PER_T6);
      default: per_ticks = '0;
    endcase
  endfunction : per_ticks

  // bus handshake: one wait state, then answer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      waitrequest_ff <= 1'b1;
    else if ((read | write) & waitrequest_ff)
      waitrequest_ff <= 1'b0;
    else
      waitrequest_ff <= 1'b1;
  end

  always_comb
  begin
    rd_mux = 8'h00;
    if (address[1:0] == 2'h0)
    begin
      if (widx == IDX_WAKE_FILTER)
        rd_mux = {2'h0, wake_filter_select_ff}; // RL1
      else if (widx == IDX_TIMER_ONE)
        rd_mux = {1'b0, on_ff[0], 1'b0, per_ff[0]}; // RL1
      else if (widx == IDX_TIMER_TWO)
        rd_mux = {1'b0, on_ff[1], 1'b0, per_ff[1]}; // RL13
      else if (widx == IDX_SWITCH_ROUTE)
        rd_mux = {wake_en_ff, 6'h00};
      else if (widx == IDX_STATUS)
        rd_mux = {1'b0, wake_level_ff, hs_out_ff};
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      readdata_ff <= 32'h0000_0000;
    else if (read & waitrequest_ff)
    begin
      if (widx == IDX_SWITCH_ROUTE && address[1:0] == 2'h0)
        readdata_ff <= {18'h0, hs_cfg_ff, 2'h0} | {24'h000000, rd_mux};
      else
        readdata_ff <= {24'h000000, rd_mux};
    end
  end

  // wake filter selection register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      wake_filter_select_ff <= RST_WAKE_FILTER[5:0]; // RL14
    else if (soft_reset)
      wake_filter_select_ff <= RST_WAKE_FILTER[5:0]; // RL14
    else if (wr_ok && widx == IDX_WAKE_FILTER)
      wake_filter_select_ff <= writedata[5:0]; // RL2
  end

  // switch routing and timer wake enables
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hs_cfg_ff  <= RST_SWITCH_ROUTE[13:2];
      wake_en_ff <= RST_SWITCH_ROUTE[1:0];
    end
    else if (soft_reset)
    begin
      hs_cfg_ff  <= RST_SWITCH_ROUTE[13:2];
      wake_en_ff <= RST_SWITCH_ROUTE[1:0];
    end
    else if (restart_req)
      hs_cfg_ff <= RST_SWITCH_ROUTE[13:2];
    else if (wr_ok && widx == IDX_SWITCH_ROUTE)
    begin
      hs_cfg_ff  <= writedata[13:2];
      wake_en_ff <= writedata[WKEN_LSB+1:WKEN_LSB]; // RL15
    end
  end

  // 0.1 ms time base
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_ff <= 16'h0000;
    else if (tick)
      tick_cnt_ff <= 16'h0000;
    else
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
  end

  genvar t;
  generate
    for (t = 0; t < 2; t++)
    begin : g_timer
      logic [TCNT_W-1:0] cnt_ff;
      logic              run;
      logic [7:0]        my_idx;
      assign my_idx = (t == 0) ? IDX_TIMER_ONE : IDX_TIMER_TWO;
      assign run = (on_ff[t] != ON_HOLD_LOW) && (on_ff[t] != ON_HOLD_HIGH) &&
                   (on_ff[t] != ON_RESERVED) && (per_ff[t] != PER_RESERVED);
      // a write of a running on-time code starts the timer
      assign start[t] = wr_ok && (widx == my_idx) &&
                        (on_ticks(writedata[ON_LSB+2:ON_LSB]) != '0) &&
                        (writedata[PER_LSB+2:PER_LSB] != PER_RESERVED); // RL10

      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          on_ff[t]  <= RST_TIMER[ON_LSB+2:ON_LSB]; // RL14
          per_ff[t] <= RST_TIMER[PER_LSB+2:PER_LSB];
        end
        else if (soft_reset || restart_req)
        begin
          on_ff[t]  <= RST_TIMER[ON_LSB+2:ON_LSB]; // RL11 RL14
          per_ff[t] <= RST_TIMER[PER_LSB+2:PER_LSB];
        end
        else if (wr_ok && widx == my_idx)
        begin
          on_ff[t]  <= writedata[ON_LSB+2:ON_LSB]; // RL13
          per_ff[t] <= writedata[PER_LSB+2:PER_LSB];
        end
      end

      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          cnt_ff <= '0;
        else if (start[t] || !run)
          cnt_ff <= '0;
        else if (tick)
          cnt_ff <= (cnt_ff == per_ticks(per_ff[t]) - 1'b1) ? '0 : cnt_ff + 1'b1; // RL9
      end

      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          timer_out_ff[t] <= 1'b0;
          timer_end_ff[t] <= 1'b0;
          cyc_wake_ff[t]  <= 1'b0;
        end
        else if (start[t])
        begin
          timer_out_ff[t] <= 1'b1; // RL10
          timer_end_ff[t] <= 1'b0;
          cyc_wake_ff[t]  <= 1'b0;
        end
        else if (!run)
        begin
          timer_out_ff[t] <= (on_ff[t] == ON_HOLD_HIGH); // RL7 RL8
          timer_end_ff[t] <= 1'b0;
          cyc_wake_ff[t]  <= 1'b0;
        end
        else
        begin
          timer_end_ff[t] <= tick && (cnt_ff == on_ticks(on_ff[t]) - 1'b1);
          cyc_wake_ff[t]  <= tick && wake_en_ff[t] &&
                             (cnt_ff == per_ticks(per_ff[t]) - 1'b1); // RL12 RL15
          if (tick && cnt_ff == per_ticks(per_ff[t]) - 1'b1)
            timer_out_ff[t] <= 1'b1; // RL17
          else if (tick && cnt_ff == on_ticks(on_ff[t]) - 1'b1)
            timer_out_ff[t] <= 1'b0; // RL6 RL17
        end
      end
    end
  endgenerate

  // switch outputs
  genvar h;
  generate
    for (h = 0; h < 4; h++)
    begin : g_switch
      logic [2:0] cfg;
      assign cfg = hs_cfg_ff[h*HS_WIDTH +: HS_WIDTH];
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          hs_out_ff[h] <= 1'b0;
        else if (cfg == HS_ON)
          hs_out_ff[h] <= 1'b1;
        else if (cfg == HS_TIMER_ONE)
          hs_out_ff[h] <= timer_out_ff[0]; // RL16 RL12
        else if (cfg == HS_TIMER_TWO)
          hs_out_ff[h] <= timer_out_ff[1]; // RL16
        else
          hs_out_ff[h] <= 1'b0;
      end
    end
  endgenerate

  // wake input filters
  genvar w;
  generate
    for (w = 0; w < 3; w++)
    begin : g_wake
      logic [1:0]  sel;
      logic [15:0] fcnt_ff;
      logic        flt_ff;
      logic        active;
      logic [15:0] thr;
      assign sel = wake_filter_select_ff[w*FILT_WIDTH +: FILT_WIDTH];
      assign thr = (sel == FILT_STATIC_LONG) ? 16'(FLONG_CYC) : 16'(FSHORT_CYC); // RL3
      // cyclic sensing only filters while the chosen timer powers the input
      assign active = (sel == FILT_CYCLIC_ONE) ? timer_out_ff[0] :
                      (sel == FILT_CYCLIC_TWO) ? timer_out_ff[1] : 1'b1; // RL4

      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          fcnt_ff <= 16'h0000;
          flt_ff  <= 1'b0;
        end
        else if (!active || wake_input[w] == flt_ff)
          fcnt_ff <= 16'h0000;
        else if (fcnt_ff == thr - 16'h0001)
        begin
          fcnt_ff <= 16'h0000;
          flt_ff  <= wake_input[w]; // RL3
        end
        else
          fcnt_ff <= fcnt_ff + 16'h0001;
      end

      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          wake_level_ff[w] <= 1'b0;
        else if (sel == FILT_CYCLIC_ONE)
        begin
          if (timer_end_ff[0])
            wake_level_ff[w] <= flt_ff; // RL4
        end
        else if (sel == FILT_CYCLIC_TWO)
        begin
          if (timer_end_ff[1])
            wake_level_ff[w] <= flt_ff; // RL4
        end
        else
          wake_level_ff[w] <= flt_ff;
      end

      a_cyclic_sample_point: // RL4
        assert property (@(posedge clock) disable iff (!rst_n)
          (sel == FILT_CYCLIC_ONE && $past(sel) == FILT_CYCLIC_ONE &&
           wake_level_ff[w] != $past(wake_level_ff[w])) |-> $past(timer_end_ff[0]))
        else $error("cyclic wake level changed away from timer end");
    end
  endgenerate

  assign waitrequest             = waitrequest_ff;
  assign readdata                = readdata_ff;
  assign high_side_switch_output = hs_out_ff;
  assign wake_level              = wake_level_ff;
  assign cyclic_wake_pulse       = cyc_wake_ff;

  a_reserved_read_zero: // RL1
    assert property (@(posedge clock) disable iff (!rst_n)
      (read && !waitrequest_ff && address[1:0] == 2'h0 &&
       (widx == IDX_TIMER_ONE || widx == IDX_TIMER_TWO)) |->
      (readdata_ff[7] == 1'b0 && readdata_ff[3] == 1'b0))
    else $error("reserved timer bits read nonzero");

  a_filter_layout_kept: // RL2
    assert property (@(posedge clock) disable iff (!rst_n)
      (wr_ok && widx == IDX_WAKE_FILTER && !soft_reset) |=>
      wake_filter_select_ff == $past(writedata[5:0]))
    else $error("filter register did not take write");

  a_hold_low_stop: // RL7
    assert property (@(posedge clock) disable iff (!rst_n)
      (on_ff[0] == ON_HOLD_LOW && !start[0]) [*2] |-> !timer_out_ff[0])
    else $error("timer one output high while held low");

  a_hold_high_stop: // RL8
    assert property (@(posedge clock) disable iff (!rst_n)
      (on_ff[1] == ON_HOLD_HIGH && !start[1]) [*2] |-> timer_out_ff[1])
    else $error("timer two output low while held high");

  a_start_on_write: // RL10
    assert property (@(posedge clock) disable iff (!rst_n)
      start[0] |=> (timer_out_ff[0] && !timer_end_ff[0]))
    else $error("timer one did not start on write");

  a_restart_clears_timer: // RL11
    assert property (@(posedge clock) disable iff (!rst_n)
      restart_req |=> (on_ff[0] == 3'h0 && per_ff[0] == 3'h0 &&
                       on_ff[1] == 3'h0 && per_ff[1] == 3'h0 && hs_cfg_ff == 12'h000))
    else $error("restart left timer settings");

  a_restart_keeps_filter: // RL14
    assert property (@(posedge clock) disable iff (!rst_n)
      (restart_req && !soft_reset && !wr_ok) |=> $stable(wake_filter_select_ff))
    else $error("restart disturbed filter selections");

  a_switch_follows_timer: // RL16
    assert property (@(posedge clock) disable iff (!rst_n)
      (hs_cfg_ff[8:6] == HS_TIMER_TWO) |=> hs_out_ff[2] == $past(timer_out_ff[1]))
    else $error("switch three not following timer two");

  a_wake_needs_enable: // RL15
    assert property (@(posedge clock) disable iff (!rst_n)
      cyc_wake_ff[0] |-> ($past(wake_en_ff[0]) && $past(tick) && timer_out_ff[0]))
    else $error("cyclic wake without enable or period start");

  a_end_drops_output: // RL17
    assert property (@(posedge clock) disable iff (!rst_n)
      (timer_end_ff[1] && on_ff[1] != 3'h0 && $past(per_ff[1]) == per_ff[1] &&
       on_ticks(on_ff[1]) < per_ticks(per_ff[1]) &&
       $stable(on_ff[1])) |-> (!timer_out_ff[1] || cyc_wake_ff[1] || $past(start[1])))
    else $error("timer two output still high after on-time");

endmodule : cstwf_top

// File: verification/cstwf_wake_model.sv
// model of the wake pins wired through sensed contacts
// assumes switch h powers the contact on wake pin h
`timescale 1ns/100ps
module cstwf_wake_model (
  // switch drive
  input  wire logic [3:0] hs,
  // bench controls
  input  wire logic [2:0] sense,
  input  wire logic [2:0] contact,
  input  wire logic [2:0] direct,
  // wake pins
  output logic      [2:0] wake_pin
);
  // unpowered sensed pin is pulled down
  always_comb
  begin
    for (int j = 0; j < 3; j++)
    begin
      wake_pin[j] = sense[j] ? (contact[j] & hs[j]) : direct[j];
    end
  end
endmodule : cstwf_wake_model

// File: verification/cyclic_sense_timers_wake_filter_tb_top.sv
// bench for the cyclic sense timers and wake filter block
// assumes shortened tick and filter counts set at the instance
`timescale 1ns/100ps
module cyclic_sense_timers_wake_filter_tb_top;
  import cstwf_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        soft_reset = 1'b0;
  logic        restart_req = 1'b0;
  logic [2:0]  wake_input;
  logic [3:0]  hs;
  logic [2:0]  wake_level;
  logic [1:0]  cyclic_wake_pulse;
  logic [2:0]  sense = 3'h0;
  logic [2:0]  contact = 3'h0;
  logic [2:0]  direct = 3'h0;
  logic [3:0]  be_v = 4'hf;
  int          err_count = 0;
  int          n_tests = 0;
  int          n;
  int          ont [5] = '{10, 30, 100, 1000, 2000};
  wire  [8:0]  obs = {cyclic_wake_pulse, wake_level, hs};

  always #2.5 clock = ~clock;

  cstwf_top #(.TICK_CYC(10), .FSHORT_CYC(4), .FLONG_CYC(8)) dut (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .soft_reset(soft_reset), .restart_req(restart_req),
    .wake_input(wake_input), .high_side_switch_output(hs), .wake_level(wake_level),
    .cyclic_wake_pulse(cyclic_wake_pulse)
  );

  cstwf_wake_model partner (
    .hs(hs), .sense(sense), .contact(contact), .direct(direct), .wake_pin(wake_input)
  );

  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    byteenable <= be_v;
    write <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge clock);
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
    @(posedge clock);
  endtask : bus_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, d);
    chk(d, exp);
  endtask : rd_chk

  // counts edges until the watched output reaches v
  task automatic wait_lvl(input int i, input logic v, input int lim, output int c);
    c = 0;
    while (obs[i] !== v && c < lim)
    begin
      @(posedge clock);
      c++;
    end
  endtask : wait_lvl

  // start a timer, then time the first low phase and the second high phase
  task automatic meas(input int i, input logic [7:0] a, input logic [7:0] d,
                      input int lo, input int hi);
    int c;
    bus_wr(a, {24'h0, d});
    wait_lvl(i, 1'b1, 50, c);
    chk(32'(c < 5), 32'h1);
    wait_lvl(i, 1'b0, 5000, c);
    wait_lvl(i, 1'b1, 9000, c);
    chk(32'(c), 32'(lo));
    wait_lvl(i, 1'b0, 5000, c);
    chk(32'(c), 32'(hi));
  endtask : meas

  task automatic done_t(input string s);
    $display("test %s done", s);
  endtask : done_t

  initial
  begin
    #300000;
    err_count++;
    final_report();
  end

  initial
  begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd_chk(8'h24, 32'h0);
    rd_chk(8'h30, 32'h0);
    rd_chk(8'h34, 32'h0);
    rd_chk(8'h28, 32'h0);
    rd_chk(8'h25, 32'h0);
    done_t("reset");
    // in two on the long filter, in one on the short one
    bus_wr(8'h24, 32'h04);
    direct <= 3'b011;
    repeat (6) @(posedge clock);
    direct <= 3'b000;
    repeat (2) @(posedge clock);
    chk({30'h0, wake_level[1:0]}, 32'h1);
    repeat (10) @(posedge clock);
    direct <= 3'b011;
    repeat (12) @(posedge clock);
    chk({30'h0, wake_level[1:0]}, 32'h3);
    direct <= 3'b000;
    repeat (12) @(posedge clock);
    done_t("static filter");
    bus_wr(8'h24, 32'hff);
    rd_chk(8'h24, 32'h3f);
    bus_wr(8'h30, 32'hff);
    rd_chk(8'h30, 32'h77);
    bus_wr(8'h34, 32'hff);
    rd_chk(8'h34, 32'h77);
    be_v = 4'h0;
    bus_wr(8'h24, 32'h00);
    be_v = 4'hf;
    rd_chk(8'h24, 32'h3f);
    bus_wr(8'h50, 32'hb08);
    repeat (4) @(posedge clock);
    chk({28'h0, hs & 4'hd}, 32'h8);
    bus_wr(8'h30, 32'h60);
    bus_wr(8'h34, 32'h00);
    repeat (4) @(posedge clock);
    chk({28'h0, hs & 4'h5}, 32'h1);
    bus_wr(8'h30, 32'h00);
    bus_wr(8'h34, 32'h60);
    repeat (4) @(posedge clock);
    chk({28'h0, hs & 4'h5}, 32'h4);
    done_t("codes");
    for (int k = 1; k <= 5; k++)
      meas(0, 8'h30, 8'((k << 4) | (k > 3 ? 2 : 0)), (k > 3 ? 5000 : 1000) - ont[k-1],
           ont[k-1]);
    meas(2, 8'h34, 8'h10, 990, 10);
    done_t("timing");
    bus_wr(8'h24, 32'h36);
    bus_wr(8'h30, 32'h30);
    bus_wr(8'h34, 32'h10);
    sense <= 3'b101;
    contact <= 3'b101;
    repeat (2100) @(posedge clock);
    chk({29'h0, wake_level & 3'h5}, 32'h5);
    contact <= 3'b100;
    repeat (2100) @(posedge clock);
    chk({29'h0, wake_level & 3'h5}, 32'h4);
    done_t("cyclic filter");
    bus_wr(8'h50, 32'h348);
    bus_wr(8'h30, 32'h10);
    wait_lvl(7, 1'b1, 1200, n);
    wait_lvl(7, 1'b0, 5, n);
    wait_lvl(7, 1'b1, 1200, n);
    chk(32'(n), 32'd999);
    wait_lvl(1, 1'b1, 10, n);
    chk(32'(n < 5), 32'h1);
    bus_wr(8'h50, 32'h308);
    wait_lvl(7, 1'b1, 1200, n);
    chk(32'(n), 32'd1200);
    bus_wr(8'h50, 32'h388);
    wait_lvl(8, 1'b1, 1200, n);
    chk(32'(n < 1200), 32'h1);
    done_t("cyclic wake");
    restart_req <= 1'b1;
    @(posedge clock);
    restart_req <= 1'b0;
    @(posedge clock);
    rd_chk(8'h30, 32'h0);
    rd_chk(8'h34, 32'h0);
    rd_chk(8'h24, 32'h36);
    rd_chk(8'h50, 32'h80);
    rd_chk(8'h60, 32'h40);
    repeat (3) @(posedge clock);
    chk({28'h0, hs}, 32'h0);
    bus_wr(8'h30, 32'h10);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    @(posedge clock);
    rd_chk(8'h24, 32'h0);
    rd_chk(8'h30, 32'h0);
    done_t("restart");
    final_report();
  end
endmodule : cyclic_sense_timers_wake_filter_tb_top
